// ==== swr_top.sv ====
/*
  Sleep control, wake-up detection, watchdog and reset-cause flags,
  with an APB slave for control and status.
  Assumes presetn is the power-on reset, core strobes are on pclk,
  and pins and the clear pin are asynchronous.
*/
`timescale 1ns/1ps
`include "swr_regs.svh"
module swr_top
  import swr_pkg::*;
#(
  parameter swr_tick_t DOG_PERIOD_TICKS = swr_tick_t'(`SWR_DOG_TIME_MS * `SWR_MS_TICKS),
  parameter swr_tick_t HOLD_POR_TICKS   = swr_tick_t'(`SWR_HOLD_POR_MS * `SWR_MS_TICKS),
  parameter int        TICK_CYCLES      = `SWR_TICK_CYCLES
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic [`SWR_ADDR_W-1:0]   paddr,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     sleep_req,
  input  wire logic                     port_access,
  input  wire logic [`SWR_PORT_W-1:0]   core_port_out,
  input  wire logic [`SWR_PORT_W-1:0]   core_port_oe,
  input  wire logic                     port_pin_zero,
  input  wire logic                     port_pin_one,
  input  wire logic                     port_pin_three,
  input  wire logic                     master_clear_pin,
  output logic      [`SWR_PORT_W-1:0]   pin_drive_out,
  output logic      [`SWR_PORT_W-1:0]   pin_drive_en,
  output logic                          core_reset_n,
  output logic                          core_restart,
  output logic                          osc_drive_en,
  output logic                          sleeping,
  output logic                          timeout_flag_n,
  output logic                          powerdown_flag_n,
  output logic                          pin_change_wake_flag
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int        TICK_W        = $clog2(TICK_CYCLES);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam swr_tick_t HOLD_SUB_TICKS = swr_tick_t'(`SWR_HOLD_SUB_US * `SWR_US_TICKS);

  swr_state_t                 st_q;
  swr_state_t                 st_d;
  logic                       tmo_q;
  logic                       tmo_d;
  logic                       pwdn_q;
  logic                       pwdn_d;
  logic                       gw_q;
  logic                       gw_d;
  logic                       hold_start;
  logic [`SWR_CTRL_W-1:0]     ctrl_q;
  logic [TICK_W-1:0]          div_q;
  logic                       tick;
  swr_tick_t                  dog_q;
  swr_tick_t                  hold_q;
  swr_tick_t                  hold_len_q;
  logic [`SWR_WATCH_W-1:0]    ref_q;
  logic [`SWR_WATCH_W-1:0]    pins_s;
  logic [`SWR_WATCH_W:0]      sync_q;
  logic                       clrp_s;
  logic                       restart_q;
  logic [31:0]                prdata_q;
  logic [`SWR_PORT_W-1:0]     drv_out_q;
  logic [`SWR_PORT_W-1:0]     drv_en_q;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  swr_sync #(
    .W   (`SWR_WATCH_W + 1),
    .RST (`SWR_SYNC_RST)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({master_clear_pin, port_pin_three, port_pin_one, port_pin_zero}),
    .q     (sync_q)
  );

  assign clrp_s = sync_q[`SWR_WATCH_W];
  assign pins_s = sync_q[`SWR_WATCH_W-1:0];

  // ----------------------------------------------------------------
  // wake and reset sources
  // ----------------------------------------------------------------
  wire dog_en    = ctrl_q[`SWR_CTRL_DOG_BIT];
  wire wake_en   = ctrl_q[`SWR_CTRL_WAKE_BIT];
  wire clrp_en   = ctrl_q[`SWR_CTRL_CLRP_BIT];
  wire clrp_rst  = clrp_en & ~clrp_s;
  wire dog_live  = dog_en & (st_q != ST_HOLD);
  wire dog_fire  = dog_live & tick & (dog_q == DOG_PERIOD_TICKS - 16'h0001);
  wire pin_diff  = (pins_s != ref_q);
  wire pin_wake  = wake_en & pin_diff;
  wire hold_done = (hold_q >= hold_len_q);
  wire ref_load  = port_access & (st_q == ST_RUN);
  wire dog_clr   = (st_q == ST_HOLD) | (st_q == ST_RUN & sleep_req);

  // ----------------------------------------------------------------
  // 1 us tick divider
  // ----------------------------------------------------------------
  assign tick = (div_q == TICK_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
    end else begin
      div_q <= tick ? '0 : div_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // sequencer and reset-cause flags
  // ----------------------------------------------------------------
  always_comb begin
    st_d       = st_q;
    tmo_d      = tmo_q;
    pwdn_d     = pwdn_q;
    gw_d       = gw_q;
    hold_start = 1'b0;
    case (st_q)
      ST_RUN: begin
        if (clrp_rst) begin
          gw_d       = 1'b0;
          hold_start = 1'b1;
          st_d       = ST_HOLD;
        end else if (dog_fire) begin
          gw_d       = 1'b0;
          tmo_d      = 1'b0;
          hold_start = 1'b1;
          st_d       = ST_HOLD;
        end else if (sleep_req) begin
          tmo_d      = 1'b1;
          pwdn_d     = 1'b0;
          st_d       = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (clrp_rst) begin
          gw_d       = 1'b0;
          tmo_d      = 1'b1;
          pwdn_d     = 1'b0;
          hold_start = 1'b1;
          st_d       = ST_HOLD;
        end else if (dog_fire) begin
          gw_d       = 1'b0;
          tmo_d      = 1'b0;
          pwdn_d     = 1'b0;
          hold_start = 1'b1;
          st_d       = ST_HOLD;
        end else if (pin_wake) begin
          gw_d       = 1'b1;
          tmo_d      = 1'b1;
          pwdn_d     = 1'b0;
          hold_start = 1'b1;
          st_d       = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (hold_done & ~clrp_rst) begin
          st_d = ST_RUN;
        end
      end
      default: begin
        st_d = ST_HOLD;
      end
    endcase
  end

  // flags change only on the transitions above
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= ST_HOLD;
      tmo_q  <= 1'b1;
      pwdn_q <= 1'b1;
      gw_q   <= 1'b0;
    end else begin
      st_q   <= st_d;
      tmo_q  <= tmo_d;
      pwdn_q <= pwdn_d;
      gw_q   <= gw_d;
    end
  end

  // ----------------------------------------------------------------
  // watchdog counter
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dog_q <= '0;
    end else if (dog_clr | ~dog_en | dog_fire) begin
      dog_q <= '0;
    end else if (tick) begin
      dog_q <= dog_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // reset delay timer; held at zero while the clear pin is low and enabled
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q     <= '0;
      hold_len_q <= HOLD_POR_TICKS;
    end else if (hold_start) begin
      hold_q     <= '0;
      hold_len_q <= HOLD_SUB_TICKS;
    end else if (st_q == ST_HOLD & clrp_rst) begin
      hold_q     <= '0;
    end else if (st_q == ST_HOLD & tick & ~hold_done) begin
      hold_q     <= hold_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // pin-change reference and held pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q     <= '0;
      drv_out_q <= '0;
      drv_en_q  <= '0;
      restart_q <= 1'b0;
    end else begin
      if (ref_load) begin
        ref_q <= pins_s;
      end
      if (st_q != ST_SLEEP) begin
        drv_out_q <= core_port_out;
        drv_en_q  <= core_port_oe;
      end
      restart_q <= (st_q == ST_HOLD) & (st_d == ST_RUN);
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  wire sel_ctrl   = (paddr == `SWR_OFS_CTRL);
  wire sel_status = (paddr == `SWR_OFS_STATUS);
  wire sel_pins   = (paddr == `SWR_OFS_PINS);
  wire addr_hit   = sel_ctrl | sel_status | sel_pins;
  wire setup_ph   = psel & ~penable;
  wire access_ph  = psel & penable;
  wire ctrl_wr    = access_ph & pwrite & sel_ctrl & pstrb[0];

  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_ctrl) begin
      rd_mux[`SWR_CTRL_W-1:0] = ctrl_q;
    end else if (sel_status) begin
      rd_mux[`SWR_STAT_GW_BIT]   = gw_q;
      rd_mux[`SWR_STAT_TMO_BIT]  = tmo_q;
      rd_mux[`SWR_STAT_PWDN_BIT] = pwdn_q;
      rd_mux[`SWR_STAT_SLP_BIT]  = (st_q == ST_SLEEP);
      rd_mux[`SWR_STAT_HOLD_BIT] = (st_q == ST_HOLD);
    end else if (sel_pins) begin
      rd_mux[`SWR_PINS_REF_LSB +: `SWR_WATCH_W] = ref_q;
      rd_mux[`SWR_PINS_NOW_LSB +: `SWR_WATCH_W] = pins_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= `SWR_CTRL_RST;
      prdata_q <= '0;
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= pwdata[`SWR_CTRL_W-1:0];
      end
      if (setup_ph) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata               = prdata_q;
  assign pready               = 1'b1;
  assign pslverr              = access_ph & ~addr_hit;
  assign pin_drive_out        = drv_out_q;
  assign pin_drive_en         = drv_en_q;
  assign core_reset_n         = (st_q != ST_HOLD);
  assign core_restart         = restart_q;
  assign osc_drive_en         = (st_q != ST_SLEEP);
  assign sleeping             = (st_q == ST_SLEEP);
  assign timeout_flag_n       = tmo_q;
  assign powerdown_flag_n     = pwdn_q;
  assign pin_change_wake_flag = gw_q;

endmodule : swr_top

// ==== swr_regs.svh ====
/*
  Register offsets, field positions, reset values and timing figures
  for the sleep, wake-up and reset-cause block.
  Assumes a 250 MHz pclk and a 32-bit APB with byte addressing.
*/
`ifndef SWR_REGS_SVH
`define SWR_REGS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SWR_ADDR_W        12
`define SWR_OFS_CTRL      12'h000
`define SWR_OFS_STATUS    12'h004
`define SWR_OFS_PINS      12'h008

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define SWR_CTRL_W        3
`define SWR_CTRL_DOG_BIT  0
`define SWR_CTRL_WAKE_BIT 1
`define SWR_CTRL_CLRP_BIT 2
`define SWR_CTRL_RST      3'h5
`define SWR_STAT_GW_BIT   7
`define SWR_STAT_TMO_BIT  4
`define SWR_STAT_PWDN_BIT 3
`define SWR_STAT_SLP_BIT  8
`define SWR_STAT_HOLD_BIT 9
`define SWR_PINS_REF_LSB  0
`define SWR_PINS_NOW_LSB  4
`define SWR_PORT_W        6
`define SWR_WATCH_W       3
`define SWR_SYNC_RST      4'h8

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SWR_CLK_NS        4
`define SWR_TICK_NS       1000
`define SWR_TICK_CYCLES   (`SWR_TICK_NS / `SWR_CLK_NS)
`define SWR_DOG_TIME_MS   18
`define SWR_HOLD_POR_MS   1
`define SWR_HOLD_SUB_US   10
`define SWR_MS_TICKS      (1000000 / `SWR_TICK_NS)
`define SWR_US_TICKS      (1000 / `SWR_TICK_NS)

`endif

// ==== swr_pkg.sv ====
/*
  Types for the sleep, wake-up and reset-cause block.
  Assumes swr_regs.svh supplies the numeric constants.
*/
package swr_pkg;

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN,
    ST_SLEEP,
    ST_HOLD
  } swr_state_t;

  typedef logic [15:0] swr_tick_t;

endpackage : swr_pkg

// ==== swr_sync.sv ====
/*
  Two-flop synchroniser for a group of pin levels.
  Assumes each bit is an independent level; no bus coherence.
*/
`timescale 1ns/1ps
module swr_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // ----------------------------------------------------------------
  // two stages; first stage read only by the second
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST;
      q      <= RST;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : swr_sync

// ==== swr_monitor.sv ====
/*
  Concurrent checks on the swr_top ports: sleep entry, wake-up resets,
  reset-cause flags and APB responses.
  Assumes the bind after the module attaches it to every swr_top.
*/
`timescale 1ns/1ps
`include "swr_regs.svh"
module swr_monitor (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic [`SWR_ADDR_W-1:0] paddr,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   sleep_req,
  input wire logic [`SWR_PORT_W-1:0] pin_drive_out,
  input wire logic [`SWR_PORT_W-1:0] pin_drive_en,
  input wire logic                   core_reset_n,
  input wire logic                   core_restart,
  input wire logic                   osc_drive_en,
  input wire logic                   sleeping,
  input wire logic                   timeout_flag_n,
  input wire logic                   powerdown_flag_n,
  input wire logic                   pin_change_wake_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_sleep_entry: assert property (
    $rose(sleeping) |-> $past(sleep_req) && timeout_flag_n && !powerdown_flag_n)
    else $error("sleep entry flags wrong");
  a_osc_off: assert property (sleeping |-> !osc_drive_en)
    else $error("oscillator driver on in sleep");
  a_pins_frozen: assert property (
    sleeping && $past(sleeping) |-> $stable(pin_drive_out) && $stable(pin_drive_en))
    else $error("pin drive moved in sleep");
  a_wake_reset: assert property ($fell(sleeping) |-> !core_reset_n[*8])
    else $error("wake without reset delay");
  a_wake_pd: assert property ($fell(sleeping) |-> !powerdown_flag_n)
    else $error("powerdown flag set after wake");
  a_pin_wake: assert property (
    $rose(pin_change_wake_flag) |-> timeout_flag_n && !powerdown_flag_n && $past(sleeping))
    else $error("pin wake flags wrong");
  a_timeout_cause: assert property (
    $fell(timeout_flag_n) |-> !core_reset_n && !pin_change_wake_flag)
    else $error("timeout flag cleared without reset");
  a_flag_hold: assert property (
    core_reset_n && $past(core_reset_n) && !$rose(sleeping)
    |-> $stable({timeout_flag_n, powerdown_flag_n, pin_change_wake_flag}))
    else $error("flags changed without reset");
  a_restart_pulse: assert property (
    $rose(core_reset_n) |-> core_restart ##1 !core_restart)
    else $error("restart pulse missing");
  a_apb_resp: assert property (psel && penable |-> pready
    && (pslverr == !(paddr inside {`SWR_OFS_CTRL, `SWR_OFS_STATUS, `SWR_OFS_PINS})))
    else $error("apb response wrong");
  c_pin_wake: cover property ($rose(pin_change_wake_flag));
  c_dog_wake: cover property ($fell(sleeping) && !timeout_flag_n);
  c_refused: cover property (psel && penable && pslverr);
endmodule : swr_monitor

bind swr_top swr_monitor u_swr_monitor (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req),
  .pin_drive_out(pin_drive_out), .pin_drive_en(pin_drive_en),
  .core_reset_n(core_reset_n), .core_restart(core_restart),
  .osc_drive_en(osc_drive_en), .sleeping(sleeping), .timeout_flag_n(timeout_flag_n),
  .powerdown_flag_n(powerdown_flag_n), .pin_change_wake_flag(pin_change_wake_flag)
);

// ==== swr_core.sv ====
/*
  Behavioural processor core facing swr_top: port drive and strobes.
  Assumes the bench seeds $urandom and calls nap() just after an edge.
*/
`timescale 1ns/1ps
module swr_core (
  input  wire logic pclk,
  input  wire logic core_reset_n,
  output logic      sleep_req,
  output logic      port_access,
  output logic [5:0] core_port_out,
  output logic [5:0] core_port_oe
);
  initial begin
    sleep_req = 1'b0;
    port_access = 1'b0;
    core_port_out = 6'h0;
    core_port_oe = 6'h0;
  end
  // random drive, also in sleep so a leak shows; zero while held in reset
  always @(posedge pclk) begin
    core_port_out <= core_reset_n ? 6'($urandom) : 6'h0;
    core_port_oe <= core_reset_n ? 6'($urandom) : 6'h0;
  end
  task automatic nap(input bit touch);
    if (touch) begin
      port_access <= 1'b1;
      @(posedge pclk);
      port_access <= 1'b0;
    end
    sleep_req <= 1'b1;
    @(posedge pclk);
    sleep_req <= 1'b0;
  endtask : nap
endmodule : swr_core

// ==== swr_top_tb.sv ====
/*
  Self-checking bench for swr_top with a behavioural core beside it.
  Assumes shortened watchdog and reset-delay counts.
*/
`timescale 1ns/1ps
`include "swr_regs.svh"
module swr_top_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic clr_n = 1'b1;
  logic [`SWR_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [2:0] pins = 3'h0;
  logic [31:0] prdata, r;
  logic [5:0] cpo, cpe;
  logic [2:0] fl;
  logic pready, pslverr, sleep_req, port_access, core_reset_n, core_restart, sleeping, e;
  int errors = 0;
  int checks = 0;
  always #2 pclk = ~pclk;

  swr_top #(.DOG_PERIOD_TICKS(16'd20), .HOLD_POR_TICKS(16'd5), .TICK_CYCLES(4)) u_swr_top (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_req(sleep_req), .port_access(port_access),
    .core_port_out(cpo), .core_port_oe(cpe), .port_pin_zero(pins[0]),
    .port_pin_one(pins[1]), .port_pin_three(pins[2]), .master_clear_pin(clr_n),
    .pin_drive_out(), .pin_drive_en(), .core_reset_n(core_reset_n),
    .core_restart(core_restart), .osc_drive_en(), .sleeping(sleeping),
    .timeout_flag_n(fl[1]), .powerdown_flag_n(fl[0]), .pin_change_wake_flag(fl[2]));
  swr_core u_swr_core (.pclk(pclk), .core_reset_n(core_reset_n), .sleep_req(sleep_req),
    .port_access(port_access), .core_port_out(cpo), .core_port_oe(cpe));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] st(input logic g, input logic t, input logic p);
    st = 32'h0;
    st[`SWR_STAT_GW_BIT] = g;
    st[`SWR_STAT_TMO_BIT] = t;
    st[`SWR_STAT_PWDN_BIT] = p;
  endfunction : st
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    if (errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  task automatic apb(input logic w, input logic [`SWR_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [`SWR_ADDR_W-1:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask : rd
  task automatic wait_restart();
    for (int i = 0; i < 400; i++) begin
      @(posedge pclk);
      if (core_restart === 1'b1) break;
    end
    chk({31'h0, core_restart}, 32'h1);
  endtask : wait_restart
  // how: 0 flip a watched pin, 1 nothing, 2 clear-pin pulse
  task automatic nap(input bit slp, input bit touch, input int how, input logic [31:0] x);
    @(posedge pclk);
    if (slp) u_swr_core.nap(touch);
    if (how == 0) pins <= pins ^ 3'(1 << ($urandom % 3));
    if (how == 2) begin
      repeat (4) @(posedge pclk);
      clr_n <= 1'b0;
      repeat (4) @(posedge pclk);
      clr_n <= 1'b1;
    end
    wait_restart();
    rd(`SWR_OFS_STATUS, x);
    chk({29'h0, fl}, {29'h0, x[`SWR_STAT_GW_BIT], x[`SWR_STAT_TMO_BIT], x[`SWR_STAT_PWDN_BIT]});
  endtask : nap

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hd13608de));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    wait_restart();
    rd(`SWR_OFS_STATUS, st(0, 1, 1));
    rd(`SWR_OFS_CTRL, {29'h0, `SWR_CTRL_RST});
    apb(1'b0, 12'h00c, 32'h0);
    chk({r[30:0], e}, 32'h1);
    wait_restart();
    rd(`SWR_OFS_STATUS, st(0, 0, 1));
    apb(1'b1, `SWR_OFS_CTRL, 32'h6);
    nap(1, 1, 0, st(1, 1, 0));
    nap(1, 0, 1, st(1, 1, 0));
    nap(0, 0, 2, st(0, 1, 0));
    nap(1, 1, 2, st(0, 1, 0));
    apb(1'b1, `SWR_OFS_CTRL, 32'h4);
    @(posedge pclk);
    u_swr_core.nap(1'b1);
    pins <= pins ^ 3'(1 << ($urandom % 3));
    repeat (40) @(posedge pclk);
    chk({31'h0, sleeping}, 32'h1);
    apb(1'b1, `SWR_OFS_CTRL, 32'h6);
    wait_restart();
    rd(`SWR_OFS_STATUS, st(1, 1, 0));
    apb(1'b1, `SWR_OFS_CTRL, 32'h1);
    nap(1, 1, 1, st(0, 0, 0));
    conclude();
  end
  // hang guard, well past the several hundred cycles the run needs
  initial begin
    #80000;
    errors++;
    conclude();
  end
endmodule : swr_top_tb
